// ---- src/cpucrs_pkg.sv ----
// Constants, types and decode helpers for the core register set
package cpucrs_pkg;
  localparam int DW  = 8;
  localparam int PCW = 16;
  localparam int RSW = 9;
  localparam int PROG_BYTES = 8192;
  localparam int PROG_AW    = 13;

  localparam logic [DW-1:0]  F_RST   = 8'h02;
  localparam logic [DW-1:0]  ACC_RST = 8'h00;
  localparam logic [DW-1:0]  X_RST   = 8'h00;
  localparam logic [DW-1:0]  SP_RST  = 8'h00;
  localparam logic [PCW-1:0] PC_RST  = 16'h0000;
  localparam logic [PCW-1:0] PC_ONE  = 16'h0001;

  localparam int F_GIE   = 0;
  localparam int F_ZERO  = 1;
  localparam int F_CARRY = 2;
  localparam int F_SUPER = 3;
  localparam int F_BANK  = 4;
  // Software may touch bank, carry, zero and interrupt enable only
  localparam logic [DW-1:0] F_WMASK = 8'h17;
  localparam logic [DW-1:0] F_IMPL  = 8'h1F;
  localparam logic [DW-1:0] ZERO8   = 8'h00;

  localparam logic [RSW-1:0] RS_ADDR_F   = 9'h0F7;
  localparam logic [RSW-1:0] RS_EXT_BASE = 9'h100;

  localparam logic [DW-1:0] SP_STEP1 = 8'h01;
  localparam logic [DW-1:0] SP_STEP2 = 8'h02;
  localparam logic [DW-1:0] SP_STEP3 = 8'h03;

  typedef enum logic [2:0] {
    SP_HOLD, SP_PUSH, SP_POP, SP_CALL, SP_RET, SP_RETI, SP_SWAP, SP_ADD
  } cpucrs_sp_op_e;

  function automatic logic is_flags_addr(input logic [RSW-1:0] a);
    return a == RS_ADDR_F;
  endfunction

  function automatic logic is_ext_addr(input logic [RSW-1:0] a);
    return a >= RS_EXT_BASE;
  endfunction
endpackage

// ---- src/cpucrs_flags.sv ----
// Flags register with protected supervisory bit
`timescale 1ns/1ns
module cpucrs_flags
  import cpucrs_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          alu_upd,
  input  wire logic [DW-1:0] alu_res,
  input  wire logic          alu_cy,
  input  wire logic          f_or,
  input  wire logic          f_and,
  input  wire logic [DW-1:0] f_imm,
  input  wire logic          f_rest,
  input  wire logic [DW-1:0] f_rest_val,
  input  wire logic          sup_enter,
  input  wire logic          sup_exit,
  output logic      [DW-1:0] flags_q
);
  logic [DW-1:0] flags_d;
  logic [DW-1:0] sw_val;

  always_comb begin
    flags_d = flags_q;
    sw_val  = flags_q;
    if (alu_upd) begin
      flags_d[F_ZERO]  = (alu_res == ZERO8);
      flags_d[F_CARRY] = alu_cy;
    end
    if (f_or) begin
      sw_val = flags_q | f_imm;
    end else if (f_and) begin
      sw_val = flags_q & f_imm;
    end else if (f_rest) begin
      sw_val = f_rest_val;
    end
    // Super bit never taken from software data
    if (f_or || f_and || f_rest) begin
      flags_d = (flags_d & ~F_WMASK) | (sw_val & F_WMASK);
    end
    if (sup_enter) begin
      flags_d[F_SUPER] = 1'b1;
    end else if (sup_exit) begin
      flags_d[F_SUPER] = 1'b0;
    end
    flags_d = flags_d & F_IMPL;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flags_q <= F_RST;
    end else begin
      flags_q <= flags_d;
    end
  end
endmodule

// ---- src/cpucrs_sp.sv ----
// Stack pointer with stack-instruction stepping
`timescale 1ns/1ns
module cpucrs_sp
  import cpucrs_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  cpucrs_sp_op_e      sp_op,
  input  wire logic [DW-1:0] sp_wdata,
  output logic      [DW-1:0] sp_q
);
  logic [DW-1:0] sp_d;

  // Stack grows upward; calls push two address bytes
  always_comb begin
    sp_d = sp_q;
    case (sp_op)
      SP_PUSH: sp_d = sp_q + SP_STEP1;
      SP_POP:  sp_d = sp_q - SP_STEP1;
      SP_CALL: sp_d = sp_q + SP_STEP2;
      SP_RET:  sp_d = sp_q - SP_STEP2;
      SP_RETI: sp_d = sp_q - SP_STEP3;
      SP_SWAP: sp_d = sp_wdata;
      SP_ADD:  sp_d = sp_q + sp_wdata;
      default: sp_d = sp_q;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sp_q <= SP_RST;
    end else begin
      sp_q <= sp_d;
    end
  end
endmodule

// ---- src/cpucrs_top.sv ----
// Core working register set: PC, A, X, SP, flags and flags read port
`timescale 1ns/1ns
module cpucrs_top
  import cpucrs_pkg::*;
(
  input  wire logic           clk,
  input  wire logic           rst_n,
  input  wire logic           pc_inc,
  input  wire logic           pc_load,
  input  wire logic [PCW-1:0] pc_load_val,
  input  wire logic           pc_rel,
  input  wire logic [DW-1:0]  pc_rel_off,
  input  wire logic           acc_we,
  input  wire logic [DW-1:0]  acc_wdata,
  input  wire logic           x_we,
  input  wire logic [DW-1:0]  x_wdata,
  input  cpucrs_sp_op_e       sp_op,
  input  wire logic [DW-1:0]  sp_wdata,
  input  wire logic           alu_upd,
  input  wire logic [DW-1:0]  alu_res,
  input  wire logic           alu_cy,
  input  wire logic           f_or,
  input  wire logic           f_and,
  input  wire logic [DW-1:0]  f_imm,
  input  wire logic           f_rest,
  input  wire logic [DW-1:0]  f_rest_val,
  input  wire logic           sup_enter,
  input  wire logic           sup_exit,
  input  wire logic           ix_req,
  input  wire logic [DW-1:0]  ix_base,
  input  wire logic           rs_rd,
  input  wire logic [RSW-1:0] rs_addr,
  output logic      [DW-1:0]  pc_high_q,
  output logic      [DW-1:0]  pc_low_q,
  output logic      [PROG_AW-1:0] prog_addr_q,
  output logic                pc_in_range_q,
  output logic      [DW-1:0]  acc_q,
  output logic      [DW-1:0]  x_q,
  output logic      [DW-1:0]  sp_q,
  output logic      [DW-1:0]  flags_q,
  output logic                irq_enable_q,
  output logic                sup_mode_q,
  output logic      [DW-1:0]  ix_addr_q,
  output logic                ix_valid_q,
  output logic      [DW-1:0]  rs_rdata_q,
  output logic                rs_hit_q,
  output logic                rs_ext_grant_q,
  output logic                rs_ext_block_q
);
  logic [PCW-1:0] pc_q;
  logic [PCW-1:0] pc_d;
  logic [PCW-1:0] rel_ext;
  logic [DW-1:0]  acc_d;
  logic [DW-1:0]  ix_sum;
  logic [DW-1:0]  flags_d;
  logic           rs_f;
  logic           rs_x;

  assign rel_ext = {{(PCW-DW){pc_rel_off[DW-1]}}, pc_rel_off};
  assign ix_sum  = ix_base + x_q;
  assign rs_f    = is_flags_addr(rs_addr);
  assign rs_x    = is_ext_addr(rs_addr);

  // Flags live in their own unit; the copy here feeds the read port
  cpucrs_flags u_flags (
    .clk        (clk),
    .rst_n      (rst_n),
    .alu_upd    (alu_upd),
    .alu_res    (alu_res),
    .alu_cy     (alu_cy),
    .f_or       (f_or),
    .f_and      (f_and),
    .f_imm      (f_imm),
    .f_rest     (f_rest),
    .f_rest_val (f_rest_val),
    .sup_enter  (sup_enter),
    .sup_exit   (sup_exit),
    .flags_q    (flags_d)
  );

  cpucrs_sp u_sp (
    .clk      (clk),
    .rst_n    (rst_n),
    .sp_op    (sp_op),
    .sp_wdata (sp_wdata),
    .sp_q     (sp_q)
  );

  // Program counter: load beats relative branch beats increment
  always_comb begin
    pc_d = pc_q;
    if (pc_load) begin
      pc_d = pc_load_val;
    end else if (pc_rel) begin
      pc_d = pc_q + rel_ext;
    end else if (pc_inc) begin
      pc_d = pc_q + PC_ONE;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pc_q <= PC_RST;
    end else begin
      pc_q <= pc_d;
    end
  end

  // Byte views and fetch address registered alongside the counter
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pc_high_q     <= PC_RST[PCW-1:DW];
      pc_low_q      <= PC_RST[DW-1:0];
      prog_addr_q   <= PC_RST[PROG_AW-1:0];
      pc_in_range_q <= 1'b1;
    end else begin
      pc_high_q     <= pc_d[PCW-1:DW];
      pc_low_q      <= pc_d[DW-1:0];
      prog_addr_q   <= pc_d[PROG_AW-1:0];
      pc_in_range_q <= (pc_d < PCW'(PROG_BYTES));
    end
  end

  // Swap with SP hands the old SP to A in the same cycle unless acc_we also writes A
  always_comb begin
    acc_d = acc_q;
    if (acc_we) begin
      acc_d = acc_wdata;
    end else if (sp_op == SP_SWAP) begin
      acc_d = sp_q;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      acc_q <= ACC_RST;
    end else begin
      acc_q <= acc_d;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      x_q <= X_RST;
    end else if (x_we) begin
      x_q <= x_wdata;
    end
  end

  // Effective address wraps in eight bits, as the data space does
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ix_addr_q  <= ZERO8;
      ix_valid_q <= 1'b0;
    end else begin
      ix_valid_q <= ix_req;
      if (ix_req) begin
        ix_addr_q <= ix_sum;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flags_q      <= F_RST;
      irq_enable_q <= F_RST[F_GIE];
      sup_mode_q   <= F_RST[F_SUPER];
    end else begin
      flags_q      <= flags_d;
      irq_enable_q <= flags_d[F_GIE];
      sup_mode_q   <= flags_d[F_SUPER];
    end
  end

  // Only the flags answer here; other core registers stay unmapped
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rs_rdata_q     <= ZERO8;
      rs_hit_q       <= 1'b0;
      rs_ext_grant_q <= 1'b0;
      rs_ext_block_q <= 1'b0;
    end else begin
      rs_hit_q       <= rs_rd && rs_f;
      rs_ext_grant_q <= rs_rd && rs_x && flags_q[F_BANK];
      rs_ext_block_q <= rs_rd && rs_x && !flags_q[F_BANK];
      if (rs_rd && rs_f) begin
        rs_rdata_q <= flags_q;
      end else if (rs_rd) begin
        rs_rdata_q <= ZERO8;
      end
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_flags_read;
    rs_rd && rs_f;
  endsequence

  sequence s_ext_read;
    rs_rd && rs_x;
  endsequence

  sequence s_sw_flag_op;
    (f_or || f_and || f_rest) && !sup_enter && !sup_exit;
  endsequence

  sequence s_plain_inc;
    pc_inc && !pc_load && !pc_rel;
  endsequence

  AST_PC_INC: assert property (
    s_plain_inc ##1 (!pc_load && !pc_rel && !pc_inc) |=>
      {pc_high_q, pc_low_q} == $past({pc_high_q, pc_low_q}, 2) + PC_ONE)
    else $error("pc did not advance by one");

  AST_PC_LOAD: assert property (
    pc_load |=> pc_high_q == $past(pc_load_val[PCW-1:DW])
            && pc_low_q == $past(pc_load_val[DW-1:0]))
    else $error("pc byte views wrong after load");

  AST_ACC_WR: assert property (
    acc_we |=> acc_q == $past(acc_wdata))
    else $error("accumulator missed result");

  AST_IX_ADDR: assert property (
    ix_req |=> ix_valid_q && ix_addr_q == $past(ix_sum))
    else $error("indexed address not base plus index");

  AST_SP_PUSH: assert property (
    sp_op == SP_PUSH |=> sp_q == $past(sp_q) + SP_STEP1)
    else $error("push did not step sp");

  AST_SP_RETI: assert property (
    sp_op == SP_RETI |=> sp_q == $past(sp_q) - SP_STEP3)
    else $error("reti did not unwind sp by three");

  AST_SWAP: assert property (
    sp_op == SP_SWAP && !acc_we |=>
      sp_q == $past(sp_wdata) && acc_q == $past(sp_q))
    else $error("swap with sp wrong");

  AST_ZERO: assert property (
    alu_upd && !f_or && !f_and && !f_rest |=>
      ##1 flags_q[F_ZERO] == ($past(alu_res, 2) == ZERO8))
    else $error("zero flag does not match result");

  AST_CARRY: assert property (
    alu_upd && !f_or && !f_and && !f_rest |=>
      ##1 flags_q[F_CARRY] == $past(alu_cy, 2))
    else $error("carry flag does not match alu");

  AST_SUPER_RO: assert property (
    s_sw_flag_op ##1 (!sup_enter && !sup_exit) |=> $stable(flags_q[F_SUPER]))
    else $error("software changed supervisory bit");

  AST_OR_SET: assert property (
    f_or && !sup_enter && !sup_exit |=>
      ##1 (flags_q & $past(f_imm, 2) & F_WMASK) == ($past(f_imm, 2) & F_WMASK))
    else $error("or immediate failed to set flags");

  AST_RS_READ: assert property (
    s_flags_read |=> rs_hit_q && rs_rdata_q == $past(flags_q))
    else $error("flags not returned at fixed address");

  AST_EXT_GATE: assert property (
    s_ext_read |=> (rs_ext_grant_q == $past(flags_q[F_BANK]))
                && (rs_ext_block_q != rs_ext_grant_q))
    else $error("extended access ignores bank select");

  // OR wins over AND in one cycle, so only a lone AND must clear the enable
  AST_GIE: assert property (
    f_and && !f_or && !f_imm[F_GIE] |=> ##1 !irq_enable_q)
    else $error("interrupt enable not cleared");

  AST_PC_REL: assert property (
    pc_rel && !pc_load |=>
      {pc_high_q, pc_low_q} == $past({pc_high_q, pc_low_q}) + $past(rel_ext))
    else $error("relative branch landed wrong");

  AST_X_WR: assert property (
    x_we |=> x_q == $past(x_wdata))
    else $error("index register missed write");

  AST_IX_IDLE: assert property (
    !ix_req |=> !ix_valid_q && $stable(ix_addr_q))
    else $error("indexed address moved without request");

  AST_SP_HOLD: assert property (
    sp_op == SP_HOLD |=> $stable(sp_q))
    else $error("sp moved without a stack op");

  AST_SP_POP: assert property (
    sp_op == SP_POP |=> sp_q == $past(sp_q) - SP_STEP1)
    else $error("pop did not step sp");

  AST_SP_CALL: assert property (
    sp_op == SP_CALL |=> sp_q == $past(sp_q) + SP_STEP2)
    else $error("call did not step sp by two");

  AST_SP_RET: assert property (
    sp_op == SP_RET |=> sp_q == $past(sp_q) - SP_STEP2)
    else $error("return did not unwind sp by two");

  AST_SP_ADD: assert property (
    sp_op == SP_ADD |=> sp_q == $past(sp_q) + $past(sp_wdata))
    else $error("add to sp wrong");

  AST_SUPER_SET: assert property (
    sup_enter |=> ##1 sup_mode_q)
    else $error("supervisory bit not set on entry");

  AST_SUPER_CLR: assert property (
    sup_exit && !sup_enter |=> ##1 !sup_mode_q)
    else $error("supervisory bit not cleared on exit");

  AST_AND_CLR: assert property (
    f_and && !f_or |=>
      ##1 (flags_q & ~$past(f_imm, 2) & F_WMASK) == ZERO8)
    else $error("and immediate failed to clear flags");

  AST_RSV_ZERO: assert property (
    (flags_q & ~F_IMPL) == ZERO8)
    else $error("reserved flag bits not zero");

  AST_RS_MISS: assert property (
    rs_rd && !rs_f |=> !rs_hit_q && rs_rdata_q == ZERO8)
    else $error("core register answered off the flags address");
endmodule

// ---- verif/tb_top.sv ----
// Self-checking bench for the core register set
`timescale 1ns/1ns
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_errors++; $display("Error at %0t: got %h expected %h", $time, (g), (e)); end end
module tb_top;
  import cpucrs_pkg::*;
  logic             clk, rst_n;
  logic             pc_inc, pc_load, pc_rel, acc_we, x_we, alu_upd, alu_cy;
  logic             f_or, f_and, f_rest, sup_enter, sup_exit, ix_req, rs_rd;
  logic [PCW-1:0]   pc_load_val;
  logic [DW-1:0]    pc_rel_off, acc_wdata, x_wdata, sp_wdata, alu_res, f_imm;
  logic [DW-1:0]    f_rest_val, ix_base;
  logic [RSW-1:0]   rs_addr;
  cpucrs_sp_op_e    sp_op;
  logic [DW-1:0]    pc_high_q, pc_low_q, acc_q, x_q, sp_q, flags_q, ix_addr_q, rs_rdata_q;
  logic [PROG_AW-1:0] prog_addr_q;
  logic             pc_in_range_q, irq_enable_q, sup_mode_q, ix_valid_q;
  logic             rs_hit_q, rs_ext_grant_q, rs_ext_block_q;
  int               n_errors = 0;
  int               compares = 0;

  cpucrs_top dut (.clk(clk), .rst_n(rst_n), .pc_inc(pc_inc), .pc_load(pc_load),
    .pc_load_val(pc_load_val), .pc_rel(pc_rel), .pc_rel_off(pc_rel_off), .acc_we(acc_we),
    .acc_wdata(acc_wdata), .x_we(x_we), .x_wdata(x_wdata), .sp_op(sp_op),
    .sp_wdata(sp_wdata), .alu_upd(alu_upd), .alu_res(alu_res), .alu_cy(alu_cy),
    .f_or(f_or), .f_and(f_and), .f_imm(f_imm), .f_rest(f_rest), .f_rest_val(f_rest_val),
    .sup_enter(sup_enter), .sup_exit(sup_exit), .ix_req(ix_req), .ix_base(ix_base),
    .rs_rd(rs_rd), .rs_addr(rs_addr), .pc_high_q(pc_high_q), .pc_low_q(pc_low_q),
    .prog_addr_q(prog_addr_q), .pc_in_range_q(pc_in_range_q), .acc_q(acc_q), .x_q(x_q),
    .sp_q(sp_q), .flags_q(flags_q), .irq_enable_q(irq_enable_q), .sup_mode_q(sup_mode_q),
    .ix_addr_q(ix_addr_q), .ix_valid_q(ix_valid_q), .rs_rdata_q(rs_rdata_q),
    .rs_hit_q(rs_hit_q), .rs_ext_grant_q(rs_ext_grant_q), .rs_ext_block_q(rs_ext_block_q));

  initial clk = 1'b0;
  always #5 clk = ~clk;

  // Lets one edge take the request, then drops every strobe
  task automatic tick();
    @(negedge clk);
    {pc_inc, pc_load, pc_rel, acc_we, x_we, alu_upd, f_or, f_and} = 8'h00;
    {f_rest, sup_enter, sup_exit, ix_req, rs_rd} = 5'h00;
    sp_op = SP_HOLD;
  endtask

  // Flags show two edges after the request
  task automatic fchk(input logic [DW-1:0] e);
    tick();
    tick();
    `CHK(flags_q, e)
    `CHK(irq_enable_q, e[0])
    `CHK(sup_mode_q, e[3])
  endtask

  task automatic t_reset();
    `CHK(flags_q, 8'h02)
    `CHK({acc_q, x_q, sp_q, pc_high_q, pc_low_q}, 40'h00_0000_0000)
    `CHK({pc_in_range_q, irq_enable_q, sup_mode_q, rs_hit_q}, 4'h8)
  endtask

  task automatic t_pc();
    pc_inc = 1'b1;
    tick();
    `CHK({pc_high_q, pc_low_q}, 16'h0001)
    pc_rel = 1'b1;
    pc_inc = 1'b1;
    pc_rel_off = 8'hFE;
    tick();
    `CHK({pc_high_q, pc_low_q, prog_addr_q, pc_in_range_q}, 30'h3FFF_FFFE)
    {pc_load, pc_rel, pc_inc} = 3'h7;
    pc_load_val = 16'h20FF;
    tick();
    `CHK({prog_addr_q, pc_in_range_q}, 14'h01FE)
    pc_inc = 1'b1;
    tick();
    `CHK(pc_high_q, 8'h21)
    `CHK(pc_low_q, 8'h00)
    pc_load = 1'b1;
    pc_load_val = 16'h1FFF;
    tick();
    `CHK({prog_addr_q, pc_in_range_q}, 14'h3FFF)
    // Lone increment then an idle cycle, and first address past the flash
    pc_inc = 1'b1;
    tick();
    tick();
    `CHK({pc_high_q, pc_low_q, prog_addr_q, pc_in_range_q}, 30'h0800_0000)
  endtask

  task automatic t_ax();
    {acc_we, x_we} = 2'h3;
    acc_wdata = 8'hAA;
    x_wdata = 8'h55;
    tick();
    `CHK({acc_q, x_q}, 16'hAA55)
    ix_req = 1'b1;
    ix_base = 8'hF0;
    x_we = 1'b1;
    x_wdata = 8'h20;
    tick();
    `CHK({ix_valid_q, ix_addr_q}, 9'h145)
    tick();
    `CHK({ix_valid_q, ix_addr_q, x_q}, 17'h04520)
  endtask

  task automatic t_sp();
    cpucrs_sp_op_e ops [7] = '{SP_PUSH, SP_CALL, SP_POP, SP_RET, SP_RETI, SP_ADD, SP_SWAP};
    logic [DW-1:0] e;
    logic [DW-1:0] old;
    e = 8'h00;
    for (int i = 0; i < 7; i++) begin
      old = e;
      sp_op = ops[i];
      sp_wdata = (ops[i] == SP_ADD) ? 8'h10 : 8'h80;
      case (ops[i])
        SP_PUSH: e = e + 8'h01;
        SP_CALL: e = e + 8'h02;
        SP_POP:  e = e - 8'h01;
        SP_RET:  e = e - 8'h02;
        SP_RETI: e = e - 8'h03;
        SP_ADD:  e = e + 8'h10;
        default: e = 8'h80;
      endcase
      tick();
      `CHK(sp_q, e)
    end
    `CHK(acc_q, old)
    sp_op = SP_SWAP;
    sp_wdata = 8'h40;
    acc_we = 1'b1;
    acc_wdata = 8'h77;
    tick();
    `CHK({sp_q, acc_q}, 16'h4077)
  endtask

  task automatic t_flags();
    alu_upd = 1'b1;
    alu_res = 8'h00;
    alu_cy = 1'b1;
    fchk(8'h06);
    alu_upd = 1'b1;
    alu_res = 8'h05;
    alu_cy = 1'b0;
    fchk(8'h00);
    f_or = 1'b1;
    f_imm = 8'hFF;
    fchk(8'h17);
    {f_and, alu_upd, alu_cy} = 3'h7;
    f_imm = 8'hE8;
    alu_res = 8'h00;
    fchk(8'h00);
    {sup_enter, f_or} = 2'h3;
    f_imm = 8'h10;
    fchk(8'h18);
    f_and = 1'b1;
    f_imm = 8'h00;
    fchk(8'h08);
    {sup_enter, sup_exit} = 2'h3;
    fchk(8'h08);
    sup_exit = 1'b1;
    fchk(8'h00);
    f_rest = 1'b1;
    f_rest_val = 8'hFF;
    fchk(8'h17);
    {f_or, f_and} = 2'h3;
    f_imm = 8'h00;
    fchk(8'h17);
  endtask

  task automatic rd(input logic [RSW-1:0] a, input logic [11:0] e);
    rs_rd = 1'b1;
    rs_addr = a;
    tick();
    `CHK({rs_hit_q, rs_ext_grant_q, rs_ext_block_q, 1'b0, rs_rdata_q}, e)
  endtask

  task automatic t_rs();
    rd(9'h0F7, 12'h817);
    rd(9'h1E0, 12'h400);
    rd(9'h0F6, 12'h000);
    f_and = 1'b1;
    f_imm = 8'h00;
    fchk(8'h00);
    rd(9'h1E0, 12'h200);
    tick();
    `CHK({rs_hit_q, rs_ext_grant_q, rs_ext_block_q, rs_rdata_q}, 11'h000)
  endtask

  task automatic close_out();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    rst_n = 1'b0;
    {pc_inc, pc_load, pc_rel, acc_we, x_we, alu_upd, alu_cy, f_or, f_and} = 9'h000;
    {f_rest, sup_enter, sup_exit, ix_req, rs_rd} = 5'h00;
    {pc_load_val, pc_rel_off, acc_wdata, x_wdata, sp_wdata} = 48'h0;
    {alu_res, f_imm, f_rest_val, ix_base} = 32'h0;
    rs_addr = 9'h000;
    sp_op = SP_HOLD;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    t_reset();
    t_pc();
    t_ax();
    t_sp();
    t_flags();
    t_rs();
    // Second reset in mid-run must restore every register
    rst_n = 1'b0;
    tick();
    tick();
    rst_n = 1'b1;
    t_reset();
    close_out();
  end

  // Bench needs about 50 cycles; this leaves a wide margin
  initial begin
    #20000;
    n_errors++;
    $display("Error at %0t: watchdog expired", $time);
    close_out();
  end
endmodule
